// file: logic/eac_cfg.svh
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH

// register select codes on the i/o port
`define EAC_SEL_ADDR_LOW 2'h0
`define EAC_SEL_ADDR_HIGH 2'h1
`define EAC_SEL_DATA 2'h2
`define EAC_SEL_CONTROL 2'h3

// control register fields
`define EAC_CTL_READ_BIT 0
`define EAC_CTL_WRITE_BIT 1
`define EAC_CTL_GUARD_BIT 2
`define EAC_CTL_IRQ_EN_BIT 3

// reset values
`define EAC_DATA_RESET 8'h00
`define EAC_ADDR_RESET 12'h000

// timing counts in system clocks
`define EAC_GUARD_CYCLES 3'h4
`define EAC_HALT_WRITE 3'h2
`define EAC_HALT_READ 3'h4

// write duration in oscillator cycles
`define EAC_WRITE_OSC_CYCLES 17'h10800

`endif

// file: logic/eac_pkg.sv
`default_nettype none

package eac_pkg;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
        logic irq_en;
        logic guard;
        logic [2:0] guard_cnt;
        logic busy;
        logic [11:0] wr_addr;
        logic [7:0] wr_data;
        logic [16:0] tick_cnt;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
        logic [2:0] halt_cnt;
        logic halt;
        logic [7:0] rdata;
        logic irq;
    } eac_state_t;

endpackage : eac_pkg

`default_nettype wire

// file: logic/eac_access_control.sv
// Summary of operation
// - address bits 15 to 12 always read back as zero
// - twelve-bit linear byte address, software loads it before access
// - smaller variants keep upper address bits writable but ignore them
// - data register feeds writes and receives the byte of each read
// - control bits 7 to 4 always read back as zero
// - ready interrupt while enable and global enable set and no write busy
// - master write guard clears itself four clocks after being set
// - write strobe starts a write only while the guard is set
// - no write starts while flash self-programming is busy
// - write strobe stays set during the write, cleared at completion
// - a started write halts the processor for two cycles
// - read strobe fetches the addressed byte into data at once
// - a read halts the processor for four cycles
// - while writing, reads and address changes are refused
// - write lasts 67584 oscillator cycles
// - a reset during a write lets that write complete
`timescale 1ns/1ps
`default_nettype none
`include "eac_cfg.svh"

module eac_access_control #(
    parameter int unsigned MEM_KBYTES = 4,
    parameter logic [16:0] WRITE_TICKS = `EAC_WRITE_OSC_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // processor i/o port
    input wire logic [1:0] io_sel_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    // processor status
    input wire logic gie_in,
    input wire logic flash_selfprog_busy_in,
    output logic cpu_halt_out,
    output logic nv_ready_irq_out,
    // calibrated oscillator tick, asynchronous
    input wire logic rc_tick_in
);

    logic [7:0] nv_mem [0:4095];
    eac_pkg::eac_state_t r_reg;
    eac_pkg::eac_state_t r_next;
    logic commit;

    // drop address bits that the variant ignores
    function automatic logic [11:0] eff_addr(input logic [11:0] a);
        logic [11:0] m;
        m = 12'hFFF;
        if (MEM_KBYTES == 1) begin
            m = 12'h3FF;
        end else if (MEM_KBYTES == 2) begin
            m = 12'h7FF;
        end
        return a & m;
    endfunction : eff_addr

    always_comb begin
        logic ctl_wr;
        logic start_wr;
        logic start_rd;
        logic tick_edge;
        r_next = r_reg;
        ctl_wr = io_wr_in && (io_sel_in == `EAC_SEL_CONTROL);
        start_wr = ctl_wr && io_wdata_in[`EAC_CTL_WRITE_BIT] && r_reg.guard
            && !r_reg.busy && !flash_selfprog_busy_in;
        start_rd = ctl_wr && io_wdata_in[`EAC_CTL_READ_BIT] && !r_reg.busy && !start_wr;
        tick_edge = r_reg.tick_s2 && !r_reg.tick_s3;

        r_next.tick_s1 = rc_tick_in;
        r_next.tick_s2 = r_reg.tick_s1;
        r_next.tick_s3 = r_reg.tick_s2;

        commit = 1'b0;
        if (r_reg.busy && tick_edge) begin
            if (r_reg.tick_cnt == WRITE_TICKS - 17'h1) begin
                commit = 1'b1;
            end else begin
                r_next.tick_cnt = r_reg.tick_cnt + 17'h1;
            end
        end
        if (commit) begin
            r_next.busy = 1'b0;
        end

        if (r_reg.guard) begin
            if (r_reg.guard_cnt == `EAC_GUARD_CYCLES - 3'h1) begin
                r_next.guard = 1'b0;
                r_next.guard_cnt = 3'h0;
            end else begin
                r_next.guard_cnt = r_reg.guard_cnt + 3'h1;
            end
        end

        if (r_reg.halt_cnt != 3'h0) begin
            r_next.halt_cnt = r_reg.halt_cnt - 3'h1;
        end

        if (io_wr_in) begin
            unique case (io_sel_in)
                `EAC_SEL_ADDR_LOW: begin
                    if (!r_reg.busy) begin
                        r_next.addr[7:0] = io_wdata_in;
                    end
                end
                `EAC_SEL_ADDR_HIGH: begin
                    if (!r_reg.busy) begin
                        r_next.addr[11:8] = io_wdata_in[3:0];
                    end
                end
                `EAC_SEL_DATA: begin
                    r_next.data = io_wdata_in;
                end
                `EAC_SEL_CONTROL: begin
                    r_next.irq_en = io_wdata_in[`EAC_CTL_IRQ_EN_BIT];
                    if (io_wdata_in[`EAC_CTL_GUARD_BIT]) begin
                        r_next.guard = 1'b1;
                        r_next.guard_cnt = 3'h0;
                    end
                end
            endcase
        end

        if (start_wr) begin
            r_next.busy = 1'b1;
            r_next.tick_cnt = 17'h0;
            r_next.wr_addr = eff_addr(r_reg.addr);
            r_next.wr_data = r_reg.data;
            r_next.halt_cnt = `EAC_HALT_WRITE;
        end
        if (start_rd) begin
            r_next.data = nv_mem[eff_addr(r_reg.addr)];
            r_next.halt_cnt = `EAC_HALT_READ;
        end
        r_next.halt = (r_next.halt_cnt != 3'h0);

        r_next.rdata = r_reg.rdata;
        if (io_rd_in) begin
            unique case (io_sel_in)
                `EAC_SEL_ADDR_LOW: r_next.rdata = r_reg.addr[7:0];
                `EAC_SEL_ADDR_HIGH: r_next.rdata = {4'h0, r_reg.addr[11:8]};
                `EAC_SEL_DATA: r_next.rdata = r_reg.data;
                `EAC_SEL_CONTROL: r_next.rdata = {4'h0, r_reg.irq_en, r_reg.guard,
                    r_reg.busy, 1'b0};
            endcase
        end

        r_next.irq = r_next.irq_en && gie_in && !r_next.busy;

        if (srst_in) begin
            // address reset value is arbitrary to software
            r_next.addr = `EAC_ADDR_RESET;
            r_next.data = `EAC_DATA_RESET;
            r_next.irq_en = 1'b0;
            r_next.guard = 1'b0;
            r_next.guard_cnt = 3'h0;
            r_next.halt_cnt = 3'h0;
            r_next.halt = 1'b0;
            r_next.rdata = 8'h00;
            r_next.irq = 1'b0;
            if (r_reg.busy && !commit) begin
                r_next.busy = 1'b1;
            end else begin
                r_next.busy = 1'b0;
                r_next.tick_cnt = 17'h0;
                r_next.wr_addr = 12'h000;
                r_next.wr_data = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (ce_in && commit) begin
            nv_mem[r_reg.wr_addr] <= r_reg.wr_data;
        end
    end

    assign io_rdata_out = r_reg.rdata;
    assign cpu_halt_out = r_reg.halt;
    assign nv_ready_irq_out = r_reg.irq;

    // checks assume clock enable high
    logic ctl_w;
    assign ctl_w = io_wr_in && (io_sel_in == `EAC_SEL_CONTROL);

    a_guard_timeout: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        $rose(r_reg.guard) && !ctl_w |-> r_reg.guard[*4] ##1 !r_reg.guard)
        else $error("guard did not time out after four cycles");
    a_strobe_no_guard: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        ctl_w && io_wdata_in[1] && !r_reg.guard && !r_reg.busy |=> !r_reg.busy)
        else $error("write started without guard");
    a_flash_block: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        !r_reg.busy && flash_selfprog_busy_in |=> !r_reg.busy)
        else $error("write started during flash programming");
    a_write_halt: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        $rose(r_reg.busy) |-> cpu_halt_out ##1 cpu_halt_out ##1 !cpu_halt_out)
        else $error("write halt not two cycles");
    a_read_halt: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        ctl_w && io_wdata_in[0] && !io_wdata_in[1] && !r_reg.busy
        |=> cpu_halt_out[*4] ##1 !cpu_halt_out)
        else $error("read halt not four cycles");
    a_read_data: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        ctl_w && io_wdata_in[0] && !io_wdata_in[1] && !r_reg.busy
        |=> r_reg.data == nv_mem[eff_addr($past(r_reg.addr))])
        else $error("read byte not in data register");
    a_addr_frozen: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        r_reg.busy |=> $stable(r_reg.addr))
        else $error("address changed during write");
    a_irq_level: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        r_reg.busy |-> !nv_ready_irq_out)
        else $error("ready interrupt during write");
    a_ctl_reserved: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        $past(io_rd_in && io_sel_in == `EAC_SEL_CONTROL) |-> io_rdata_out[7:4] == 4'h0)
        else $error("reserved control bits not zero");
    a_addr_reserved: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        $past(io_rd_in && io_sel_in == `EAC_SEL_ADDR_HIGH) |-> io_rdata_out[7:4] == 4'h0)
        else $error("reserved address bits not zero");
    a_busy_end: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
        commit |=> !r_reg.busy)
        else $error("strobe not cleared at completion");

    c_write_done: cover property (@(posedge clk_in) disable iff (srst_in) $fell(r_reg.busy));
    c_read: cover property (@(posedge clk_in) disable iff (srst_in) r_reg.halt_cnt == 3'h4);
    c_guard_expire: cover property (@(posedge clk_in) disable iff (srst_in)
        $fell(r_reg.guard) && !r_reg.busy);
    c_irq: cover property (@(posedge clk_in) disable iff (srst_in) $rose(nv_ready_irq_out));

endmodule : eac_access_control

`default_nettype wire

// file: tb/eac_testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } eac_row_t;

    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [1:0] io_sel_in = 2'h0;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic gie_in = 1'b0;
    logic flash_busy = 1'b0;
    logic rc_tick_in = 1'b0;
    logic [7:0] io_rdata_out;
    logic cpu_halt_out;
    logic nv_ready_irq_out;
    logic [7:0] v;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    eac_row_t rows [5];

    eac_access_control #(.MEM_KBYTES(4), .WRITE_TICKS(17'h10)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
        .io_sel_in(io_sel_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .gie_in(gie_in), .flash_selfprog_busy_in(flash_busy),
        .cpu_halt_out(cpu_halt_out), .nv_ready_irq_out(nv_ready_irq_out),
        .rc_tick_in(rc_tick_in)
    );

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    // free-running oscillator at a quarter of the clock, phase unrelated
    initial begin
        #13;
        forever #80 rc_tick_in = ~rc_tick_in;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge clk_in);
        io_sel_in = s;
        io_wdata_in = d;
        io_wr_in = 1'b1;
        @(negedge clk_in);
        io_wr_in = 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(negedge clk_in);
        io_sel_in = s;
        io_rd_in = 1'b1;
        @(negedge clk_in);
        io_rd_in = 1'b0;
        d = io_rdata_out;
    endtask : rd

    task automatic count_halt(output int c);
        c = int'(cpu_halt_out === 1'b1);
        repeat (7) begin
            @(negedge clk_in);
            c += int'(cpu_halt_out === 1'b1);
        end
    endtask : count_halt

    // poll the write-busy bit under a bounded count
    task automatic wait_idle;
        int k;
        for (k = 0; k < 300; k++) begin
            rd(2'h3, v);
            if (v[1] === 1'b0) break;
        end
        if (k == 300) num_errors++;
    endtask : wait_idle

    initial begin
        #800000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        rows[0] = '{2'h0, 8'hA5, 8'hA5};
        rows[1] = '{2'h1, 8'hFF, 8'h0F};
        rows[2] = '{2'h2, 8'h3C, 8'h3C};
        rows[3] = '{2'h3, 8'hF8, 8'h08};
        rows[4] = '{2'h3, 8'h00, 8'h00};
        repeat (10) @(negedge clk_in);
        srst_in = 1'b0;
        rd(2'h2, v);
        chk(v, 8'h00);
        rd(2'h3, v);
        chk(v, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].sel, rows[i].wdata);
            rd(rows[i].sel, v);
            chk(v, rows[i].rexp);
        end
        $display("test register table done");
        wr(2'h0, 8'h23);
        wr(2'h1, 8'h01);
        wr(2'h2, 8'h5A);
        wait_idle();
        wr(2'h3, 8'h0C);
        wr(2'h3, 8'h0A);
        gie_in = 1'b1;
        count_halt(n);
        chk(8'(n), 8'h02);
        rd(2'h3, v);
        chk(v, 8'h0A);
        chk({7'h0, nv_ready_irq_out}, 8'h00);
        wr(2'h0, 8'h77);
        wr(2'h3, 8'h09);
        count_halt(n);
        chk(8'(n), 8'h00);
        wait_idle();
        repeat (2) @(negedge clk_in);
        chk({7'h0, nv_ready_irq_out}, 8'h01);
        rd(2'h0, v);
        chk(v, 8'h23);
        wr(2'h2, 8'h00);
        @(negedge clk_in);
        gie_in = 1'b0;
        wr(2'h3, 8'h01);
        count_halt(n);
        chk(8'(n), 8'h04);
        chk({7'h0, nv_ready_irq_out}, 8'h00);
        rd(2'h2, v);
        chk(v, 8'h5A);
        $display("test write and read done");
        wr(2'h3, 8'h04);
        rd(2'h3, v);
        chk(v, 8'h04);
        repeat (3) @(negedge clk_in);
        wr(2'h3, 8'h02);
        rd(2'h3, v);
        chk(v, 8'h00);
        @(negedge clk_in);
        flash_busy = 1'b1;
        wr(2'h3, 8'h04);
        wr(2'h3, 8'h02);
        rd(2'h3, v);
        chk(v, 8'h04);
        @(negedge clk_in);
        flash_busy = 1'b0;
        $display("test guard done");
        // guard count frozen with enable low
        wr(2'h3, 8'h04);
        ce_in = 1'b0;
        repeat (6) @(negedge clk_in);
        ce_in = 1'b1;
        rd(2'h3, v);
        chk(v, 8'h04);
        $display("test clock enable done");
        wr(2'h2, 8'hC3);
        wr(2'h3, 8'h04);
        wr(2'h3, 8'h02);
        @(negedge clk_in);
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        rd(2'h3, v);
        chk(v, 8'h02);
        wait_idle();
        chk(v, 8'h00);
        wr(2'h0, 8'h23);
        wr(2'h1, 8'h01);
        wr(2'h3, 8'h01);
        rd(2'h2, v);
        chk(v, 8'hC3);
        $display("test reset during write done");
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
